// ===== rtl/poc_pkg.sv
// package for the port over-current control register bank
// assumes an Avalon-MM slave with 32-bit data and byte addresses
package poc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_DET_EN = 4'h0;
  localparam logic [3:0] OFS_IRQ_EN = 4'h4;
  localparam logic [3:0] OFS_FLAGS = 4'h8;
  // implemented bit positions: 6, 5, 4 (pins), 2 (supply), 0 (pin)
  localparam logic [7:0] IMPL_MASK = 8'h75;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam int BIT_SUPPLY = 2;
  localparam int NUM_BITS = 8;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : poc_pkg

// ===== rtl/poc_ctrl.sv
// over-current protection control and status register bank
// assumes: detector inputs are asynchronous raw levels from analog
// comparators; bus master follows Avalon-MM with waitrequest
//
// Behaviour
// - detector enable bits 6,5,4,0 per pin
// - detector enable bit 2 for supply output
// - irq enable bits 6,5,4,0 per pin
// - irq enable bit 2 gates supply
// - disabled irq masks flag, flag still records
// - pin detection sets sticky flag bit
// - supply detection sets flag bit 2
// - flags readable anytime, write one clears
// - enable registers read and write anytime
// - bits 7, 3, 1 read zero
`timescale 1ns/1ns
module poc_ctrl
  import poc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  input wire logic [NUM_BITS-1:0] i_overcurrent_raw,
  output logic [NUM_BITS-1:0] o_detector_enable,
  output logic o_overcurrent_irq
);

  logic [NUM_BITS-1:0] det_en_q;
  logic [NUM_BITS-1:0] irq_en_q;
  logic [NUM_BITS-1:0] flags_q;
  logic [NUM_BITS-1:0] flags_d;
  logic [NUM_BITS-1:0] sync1_q;
  logic [NUM_BITS-1:0] sync2_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic irq_q;
  logic [NUM_BITS-1:0] det_out_q;
  logic req;
  logic wr_take;
  logic rd_take;
  logic lane0;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_DET_EN) || (a == OFS_IRQ_EN) ||
                (a == OFS_FLAGS);
  endfunction : is_mapped

  // one wait cycle, then the answer at the edge the master sees it
  assign req = i_avs_read | i_avs_write;
  assign wr_take = i_avs_write & ack_q;
  assign rd_take = i_avs_read & ~ack_q;
  assign lane0 = i_avs_byteenable[0];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // analog comparator levels are asynchronous to the bus clock
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= RESET_VAL;
      sync2_q <= RESET_VAL;
    end else begin
      sync1_q <= i_overcurrent_raw;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      det_en_q <= RESET_VAL;
    end else if (wr_take && lane0 && i_avs_address == OFS_DET_EN) begin
      // no mode check: writable at any time
      det_en_q <= i_avs_writedata[7:0] & IMPL_MASK;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_en_q <= RESET_VAL;
    end else if (wr_take && lane0 && i_avs_address == OFS_IRQ_EN) begin
      irq_en_q <= i_avs_writedata[7:0] & IMPL_MASK;
    end
  end

  // set wins over a write-one clear arriving in the same cycle
  genvar g;
  generate
    for (g = 0; g < NUM_BITS; g++) begin : g_flag
      always_comb begin
        flags_d[g] = flags_q[g];
        if (wr_take && lane0 && i_avs_address == OFS_FLAGS &&
            i_avs_writedata[g]) begin
          flags_d[g] = 1'b0;
        end
        if (IMPL_MASK[g] && det_en_q[g] && sync2_q[g]) begin
          flags_d[g] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= RESET_VAL;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_d & irq_en_q);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      det_out_q <= RESET_VAL;
    end else begin
      det_out_q <= det_en_q;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= UNMAPPED_READ;
      resp_q <= 2'b00;
    end else if (req && !ack_q) begin
      resp_q <= is_mapped(i_avs_address) ? 2'b00 : 2'b10;
      rdata_q <= UNMAPPED_READ;
      if (rd_take) begin
        case (i_avs_address)
          OFS_DET_EN: rdata_q <= {24'h00_0000, det_en_q};
          OFS_IRQ_EN: rdata_q <= {24'h00_0000, irq_en_q};
          OFS_FLAGS: rdata_q <= {24'h00_0000, flags_q};
          default: rdata_q <= UNMAPPED_READ;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(req & ~ack_q);
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_response = resp_q;
  assign o_overcurrent_irq = irq_q;
  assign o_detector_enable = det_out_q;

endmodule : poc_ctrl

// ===== verification/poc_det_model.sv
// far-side over-current comparator model
// assumes the bench supplies the fault pattern
`timescale 1ns/1ns
module poc_det_model (
  input wire logic i_clk,
  input wire logic [7:0] i_fault,
  output logic [7:0] o_raw
);
  // always_ff also gives the comparator output one cycle of lag
  always_ff @(posedge i_clk) o_raw <= i_fault;
endmodule : poc_det_model

// ===== verification/poc_ctrl_monitor.sv
// port checks for poc_ctrl
// assumes bind onto poc_ctrl
`timescale 1ns/1ns
module poc_ctrl_monitor
  import poc_pkg::*;
(
  input wire logic i_core_clk, i_rst, i_avs_read, i_avs_write,
  input wire logic o_avs_waitrequest, o_overcurrent_irq,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic [31:0] o_avs_readdata,
  input wire logic [1:0] o_avs_response,
  input wire logic [7:0] i_overcurrent_raw, o_detector_enable
);
  logic [1:0] w_q;
  wire ack = !o_avs_waitrequest;
  wire sw = |w_q;
  always_ff @(posedge i_core_clk or posedge i_rst)
    w_q <= i_rst ? 2'h0 : {w_q[0], i_avs_write};
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_ans; (i_avs_read || i_avs_write) && !ack |=> ack; endproperty
  a_ans: assert property (p_ans) else $error("late");
  property p_one; ack |=> !ack; endproperty
  a_one: assert property (p_one) else $error("long");
  property p_rsv; ack |-> (o_avs_readdata & ~32'(IMPL_MASK)) == 0; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
  property p_err; ack |-> o_avs_response[1] == (i_avs_address > OFS_FLAGS
    || |i_avs_address[1:0]); endproperty
  a_err: assert property (p_err) else $error("map");
  property p_den; (o_detector_enable & ~IMPL_MASK) == 0; endproperty
  a_den: assert property (p_den) else $error("den");
  property p_dch; !$stable(o_detector_enable) |-> sw; endproperty
  a_dch: assert property (p_dch) else $error("dch");
  property p_up; $rose(o_overcurrent_irq) |-> sw ||
    $past(|(i_overcurrent_raw & o_detector_enable), 2); endproperty
  a_up: assert property (p_up) else $error("up");
  property p_dn; $fell(o_overcurrent_irq) |-> sw; endproperty
  a_dn: assert property (p_dn) else $error("dn");
  c_irq: cover property ($rose(o_overcurrent_irq));
  c_err: cover property (ack && o_avs_response[1]);
  c_clr: cover property ($fell(o_overcurrent_irq));
endmodule : poc_ctrl_monitor
bind poc_ctrl poc_ctrl_monitor poc_ctrl_monitor_inst (.*);

// ===== verification/poc_ctrl_tb.sv
// bench for poc_ctrl
// assumes the detector model on the raw inputs
`timescale 1ns/1ns
module poc_ctrl_tb;
  import poc_pkg::*;
  logic i_core_clk = 0, i_rst = 1, i_avs_read = 0, i_avs_write = 0;
  logic o_avs_waitrequest, o_overcurrent_irq, e;
  logic [3:0] i_avs_address = 0, i_avs_byteenable = 4'hf;
  logic [31:0] i_avs_writedata = 0, o_avs_readdata, r;
  logic [1:0] o_avs_response, rs;
  logic [7:0] i_overcurrent_raw, o_detector_enable, flt = 0, m;
  int failures = 0, checks_done = 0, cyc = 0;
  poc_ctrl poc_ctrl_inst (.*);
  poc_det_model poc_det_model_inst (.i_clk(i_core_clk), .i_fault(flt),
    .o_raw(i_overcurrent_raw));
  initial forever #50 i_core_clk = ~i_core_clk;
  task print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge i_core_clk) if (++cyc == 3000) begin
    failures++;
    print_verdict;
  end
  task chk(input string n, input logic [31:0] x, y);
    checks_done++;
    if (x !== y) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, x, y);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    {i_avs_read, i_avs_write, i_avs_address} <= {!w, w, a};
    i_avs_writedata <= {24'h00_0000, d};
    do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'b0);
    {r, rs} = {o_avs_readdata, o_avs_response};
    {i_avs_read, i_avs_write} <= 2'h0;
  endtask : bus
  initial begin
    void'($urandom(86));
    repeat (20) @(posedge i_core_clk);
    i_rst <= 0;
    for (int a = 0; a < 12; a += 4) begin
      bus(0, a, 0); chk("reset", 0, r);
      m = $urandom;
      bus(1, a, m);
      bus(0, a, 0); chk("reg", a == 8 ? 0 : m & IMPL_MASK, r);
    end
    bus(1, 4'hc, 8'hff); chk("resp", 2'h2, rs);
    for (int i = 0; i < 8; i++) if (IMPL_MASK[i]) begin
      m = 8'h01 << i;
      e = i ? $urandom % 2 : 0;
      bus(1, OFS_DET_EN, m);
      bus(1, OFS_IRQ_EN, e ? m : 8'h00);
      flt <= m;
      repeat (8) @(posedge i_core_clk);
      bus(0, OFS_FLAGS, 0); chk("flag", m, r);
      chk("irq", e, o_overcurrent_irq);
      flt <= 0;
      // let the cleared fault pass the model lag and both sync stages,
      // otherwise the still-high level re-sets the flag over the clear
      repeat (4) @(posedge i_core_clk);
      bus(1, OFS_FLAGS, m);
      bus(0, OFS_FLAGS, 0); chk("clear", 0, r);
      chk("irq", 0, o_overcurrent_irq);
    end
    bus(1, OFS_DET_EN, 0);
    flt <= 8'hff;
    repeat (8) @(posedge i_core_clk);
    bus(0, OFS_FLAGS, 0); chk("off", 0, r);
    print_verdict;
  end
endmodule : poc_ctrl_tb
